// file: src/scsa_defs.vh
// Function
// - Byte order: code, count, command, address, data
// - Count byte only in block transfers
// - Returned count includes status command byte
// - Count never includes the PEC byte
// - Byte address is dword address shifted two
// - Low byte eight bits, high byte six
// - Data bytes sent least significant first
// - Fourth data byte holds bits 31:24
// - Command bits 3:0 are byte enables
// - Command bit 4: zero write, one read
// - Bit 6 flags unclaimed last read
// - Bit 7 flags unclaimed last write
// - Clear flag means claimed, not completed
// - Code byte: end, start, function, size, PEC
// - Size: byte, word, block; one reserved
// - NACK commands while busy or data missing
// - Slave address latched from straps on the first clock after reset
`ifndef SCSA_DEFS_VH
`define SCSA_DEFS_VH
`define SCSA_CC_END       0
`define SCSA_CC_START     1
`define SCSA_CC_FUNC_LO   2
`define SCSA_CC_SIZE_LO   5
`define SCSA_CC_PEC       7
`define SCSA_FUNC_CSR     3'h0
`define SCSA_SIZE_BLOCK   2'h2
`define SCSA_CMD_RNW      4
`define SCSA_CMD_READ_UNCLAIMED_FLAG     6
`define SCSA_CMD_WRITE_UNCLAIMED_FLAG     7
`define SCSA_ADDR_FIXED   5'h1d
`define SCSA_ADDR_HI_BITS 6
`define SCSA_RD_COUNT     8'h07
`define SCSA_BIT_HALF     2
`endif

// file: src/scsa_sync.v
`timescale 1ns/1ps
module scsa_sync
(
    // Clock and reset
    input  wire core_clk,
    input  wire rst,
    // Pin in and filtered level out
    input  wire pinIn,
    output reg  level
);
reg s1;
reg s2;
reg s3;
always @(posedge core_clk)
begin
    if (rst)
    begin
        s1    <= 1'b1;
        s2    <= 1'b1;
        s3    <= 1'b1;
        level <= 1'b1;
    end
    else
    begin
        s1 <= pinIn;
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3)
            level <= s3;
    end
end
endmodule

// file: src/scsa_slave.v
`timescale 1ns/1ps
`include "scsa_defs.vh"
module scsa_slave
(
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst,
    // Address straps
    input  wire [1:0]  slave_addr_strap,
    // Serial link, open drain data
    input  wire        sclIn,
    input  wire        sdaIn,
    output wire        sdaOe_n,
    output wire        sdaOut,
    // Register access port
    output reg         csrReq,
    output reg         read_not_write,
    output reg  [15:0] csrByteAddr,
    output reg  [3:0]  csrByteEn,
    output reg  [31:0] csrWrData,
    input  wire        csrDone,
    input  wire        csrClaimed,
    input  wire [31:0] csrRdData,
    // Status
    output reg  [6:0]  slaveAddr,
    output reg         read_unclaimed_flag,
    output reg         write_unclaimed_flag
);
// ----------------------------------------
// Pin sampling
// ----------------------------------------
wire scl;
wire sda;
scsa_sync uScl (.core_clk(core_clk), .rst(rst), .pinIn(sclIn), .level(scl));
scsa_sync uSda (.core_clk(core_clk), .rst(rst), .pinIn(sdaIn), .level(sda));
reg sclD;
reg sdaD;
wire sclRise  = scl & ~sclD;
wire sclFall  = ~scl & sclD;
wire startCnd = scl & sclD & sdaD & ~sda;
wire stopCnd  = scl & sclD & ~sdaD & sda;
// ----------------------------------------
// Byte engine state
// ----------------------------------------
localparam ST_IDLE = 2'h0;
localparam ST_RX   = 2'h1;
localparam ST_ACK  = 2'h2;
localparam ST_TX   = 2'h3;
reg [1:0]  state;
reg [3:0]  bitCnt;
reg [7:0]  shReg;
reg        ackDrive;
reg        txBit;
reg        txMode;
reg [3:0]  bytePos;
reg        addrRead;
reg        isBlock;
reg        busy;
reg [7:0]  cmdByte;
reg [7:0]  addrLo;
reg [7:0]  addrHi;
reg        strapTaken;
reg        rdValid;
reg [31:0] rdData;
reg [7:0]  codeByte;
assign sdaOe_n = ~(ackDrive | (txBit == 1'b0 && state == ST_TX));
assign sdaOut  = 1'b0;
// Returned byte selection by position
function [7:0] txByte;
    input [3:0] pos;
    begin
        case (pos)
            4'h0:    txByte = `SCSA_RD_COUNT;
            4'h1:    txByte = {write_unclaimed_flag, read_unclaimed_flag, cmdByte[5:0]};
            4'h2:    txByte = addrLo;
            4'h3:    txByte = addrHi;
            4'h4:    txByte = rdData[7:0];
            4'h5:    txByte = rdData[15:8];
            4'h6:    txByte = rdData[23:16];
            4'h7:    txByte = rdData[31:24];
            default: txByte = 8'hff;
        endcase
    end
endfunction
// First bit on the wire of a returned byte
function txMsb;
    input [3:0] pos;
    reg   [7:0] full;
    begin
        full  = txByte(pos);
        txMsb = full[7];
    end
endfunction
wire [7:0] rxByte = shReg;
always @(posedge core_clk)
begin
    if (rst)
    begin
        sclD <= 1'b1;
        sdaD <= 1'b1;
        state <= ST_IDLE;
        bitCnt <= 4'h0;
        shReg <= 8'h00;
        ackDrive <= 1'b0;
        txBit <= 1'b1;
        txMode <= 1'b0;
        bytePos <= 4'h0;
        addrRead <= 1'b0;
        isBlock <= 1'b0;
        busy <= 1'b0;
        cmdByte <= 8'h00;
        addrLo <= 8'h00;
        addrHi <= 8'h00;
        codeByte <= 8'h00;
        strapTaken <= 1'b0;
        slaveAddr <= 7'h00;
        rdValid <= 1'b0;
        rdData <= 32'h00000000;
        csrReq <= 1'b0;
        read_not_write <= 1'b0;
        csrByteAddr <= 16'h0000;
        csrByteEn <= 4'h0;
        csrWrData <= 32'h00000000;
        read_unclaimed_flag <= 1'b0;
        write_unclaimed_flag <= 1'b0;
    end
    else
    begin
        sclD <= scl;
        sdaD <= sda;
        if (!strapTaken)
        begin
            strapTaken <= 1'b1;
            slaveAddr <= {`SCSA_ADDR_FIXED, slave_addr_strap};
        end
        csrReq <= 1'b0;
        if (busy && csrDone)
        begin
            busy <= 1'b0;
            if (read_not_write)
            begin
                read_unclaimed_flag <= ~csrClaimed;
                rdData <= csrRdData;
                rdValid <= 1'b1;
            end
            else
                write_unclaimed_flag <= ~csrClaimed;
        end
        if (startCnd)
        begin
            state <= ST_RX;
            bitCnt <= 4'h0;
            ackDrive <= 1'b0;
            txMode <= 1'b0;
            addrRead <= 1'b0;
            bytePos <= 4'hf;
        end
        else if (stopCnd)
        begin
            state <= ST_IDLE;
            ackDrive <= 1'b0;
        end
        else
        begin
            case (state)
                ST_RX:
                    if (sclRise)
                    begin
                        shReg <= {shReg[6:0], sda};
                        bitCnt <= bitCnt + 4'h1;
                    end
                    else if (sclFall && bitCnt == 4'h8)
                    begin
                        bitCnt <= 4'h0;
                        state <= ST_ACK;
                        ackDrive <= 1'b1;
                        if (bytePos == 4'hf)
                        begin
                            // reject when busy or data missing
                            if (rxByte[7:1] != slaveAddr || busy || (rxByte[0] && !rdValid))
                            begin
                                ackDrive <= 1'b0;
                                state <= ST_IDLE;
                            end
                            addrRead <= rxByte[0];
                            bytePos <= 4'h0;
                        end
                        else
                        begin
                            bytePos <= bytePos + 4'h1;
                            if (bytePos == 4'h0)
                            begin
                                codeByte <= rxByte;
                                isBlock <= (rxByte[6:5] == `SCSA_SIZE_BLOCK);
                                if (rxByte[4:2] != `SCSA_FUNC_CSR)
                                    ackDrive <= 1'b0;
                                if (rxByte[6:5] != `SCSA_SIZE_BLOCK)
                                    bytePos <= 4'h2;
                            end
                            else if (bytePos == 4'h2)
                                cmdByte <= rxByte;
                            else if (bytePos == 4'h3)
                                addrLo <= rxByte;
                            else if (bytePos == 4'h4)
                            begin
                                addrHi <= {2'b00, rxByte[`SCSA_ADDR_HI_BITS-1:0]};
                                if (cmdByte[`SCSA_CMD_RNW])
                                begin
                                    busy <= 1'b1;
                                    csrReq <= 1'b1;
                                    read_not_write <= 1'b1;
                                    rdValid <= 1'b0;
                                    csrByteAddr <= {rxByte[5:0], addrLo, {`SCSA_BIT_HALF{1'b0}}};
                                end
                            end
                            else if (bytePos >= 4'h5 && bytePos <= 4'h8)
                            begin
                                csrWrData <= {rxByte, csrWrData[31:8]};
                                if (bytePos == 4'h8 && !cmdByte[`SCSA_CMD_RNW])
                                begin
                                    busy <= 1'b1;
                                    csrReq <= 1'b1;
                                    read_not_write <= 1'b0;
                                    csrByteEn <= cmdByte[3:0];
                                    csrByteAddr <= {addrHi[5:0], addrLo, {`SCSA_BIT_HALF{1'b0}}};
                                end
                            end
                        end
                    end
                ST_ACK:
                    if (sclFall)
                    begin
                        ackDrive <= 1'b0;
                        if (addrRead)
                        begin
                            state <= ST_TX;
                            txMode <= 1'b1;
                            shReg <= txByte(isBlock ? 4'h0 : 4'h1);
                            txBit <= txMsb(isBlock ? 4'h0 : 4'h1);
                            bytePos <= isBlock ? 4'h0 : 4'h1;
                        end
                        else
                            state <= ST_RX;
                    end
                ST_TX:
                    if (sclFall)
                    begin
                        bitCnt <= bitCnt + 4'h1;
                        if (bitCnt == 4'h7)
                            txBit <= 1'b1;
                        else if (bitCnt == 4'h8)
                        begin
                            bitCnt <= 4'h0;
                            bytePos <= bytePos + 4'h1;
                            shReg <= txByte(bytePos + 4'h1);
                            txBit <= txMsb(bytePos + 4'h1);
                        end
                        else
                        begin
                            shReg <= {shReg[6:0], 1'b1};
                            txBit <= shReg[6];
                        end
                    end
                    else if (sclRise && bitCnt == 4'h8 && sda)
                        state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end
end
endmodule

// file: test/scsa_slave_asserts.sv
`timescale 1ns/1ps
module scsa_slave_asserts
(
    // Clock and reset
    input wire        core_clk,
    input wire        rst,
    // Observed ports
    input wire [1:0]  slave_addr_strap,
    input wire        sdaOut,
    input wire        csrReq,
    input wire        read_not_write,
    input wire [15:0] csrByteAddr,
    input wire        csrDone,
    input wire        csrClaimed,
    input wire [6:0]  slaveAddr,
    input wire        read_unclaimed_flag,
    input wire        write_unclaimed_flag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_rd_done;
        csrDone && read_not_write;
    endsequence
    sequence s_wr_done;
        csrDone && !read_not_write;
    endsequence
    a_dword_align: assert property (csrReq |-> csrByteAddr[1:0] == 2'h0)
        else $error("byte address not aligned");
    a_rd_flag_set: assert property (s_rd_done |=> read_unclaimed_flag == !$past(csrClaimed))
        else $error("read flag wrong");
    a_wr_flag_set: assert property (s_wr_done |=> write_unclaimed_flag == !$past(csrClaimed))
        else $error("write flag wrong");
    a_rd_flag_hold: assert property (!(csrDone && read_not_write) |=> $stable(read_unclaimed_flag))
        else $error("read flag moved");
    a_wr_flag_hold: assert property (!(csrDone && !read_not_write) |=> $stable(write_unclaimed_flag))
        else $error("write flag moved");
    a_req_single: assert property (csrReq |=> !csrReq)
        else $error("request longer than one cycle");
    a_addr_fixed: assert property (!$past(rst) |-> slaveAddr == {5'h1d, slave_addr_strap})
        else $error("slave address wrong");
    a_sda_low_only: assert property (sdaOut == 1'b0)
        else $error("data pin driven high");
    a_one_outstanding: assert property (csrReq |=> (!csrReq until csrDone))
        else $error("second request while access outstanding");
endmodule

// file: test/scsa_master_model.sv
`timescale 1ns/1ps
module scsa_master_model
(
    // Link pins
    output reg  scl = 1'b1,
    output reg  sdaRel = 1'b1,
    input  wire sdaLine
);
    reg [7:0] rx [0:7];
    reg       ackOk;
    reg       s;
    task bitX(input b);
    begin
        #30 sdaRel = b;
        #70 scl = 1'b1;
        #40 s = sdaLine;
        #20 scl = 1'b0;
    end
    endtask
    task byteX(input [7:0] d, input a9, output [7:0] q);
        integer i;
    begin
        for (i = 7; i >= 0; i--)
        begin
            bitX(d[i]);
            q[i] = s;
        end
        bitX(a9);
    end
    endtask
    task tx(input [7:0] d);
        reg [7:0] q;
    begin
        if (ackOk)
            byteX(d, 1'b1, q);
        ackOk = ackOk && !s;
    end
    endtask
    task startC;
    begin
        #30 sdaRel = 1'b1;
        #70 scl = 1'b1;
        #40 sdaRel = 1'b0;
        #60 scl = 1'b0;
    end
    endtask
    task xfer(input [6:0] dev, input rnw, input [1:0] size, input [2:0] fn, input [3:0] be,
              input [13:0] a, input [31:0] d);
        integer i;
        reg     blk;
    begin
        blk = size == 2'h2;
        ackOk = 1'b1;
        s = 1'b0;
        startC;
        tx({dev, 1'b0});
        tx({1'b0, size, fn, 2'h3});
        if (blk)
            tx(rnw ? 8'h03 : 8'h07);
        tx({3'h0, rnw, be});
        tx(a[7:0]);
        tx({2'h0, a[13:8]});
        for (i = 0; i < 4 && !rnw; i++)
            tx(d[8*i +: 8]);
        if (rnw && ackOk)
            startC;
        if (rnw)
            tx({dev, 1'b1});
        for (i = 0; i < 7 + blk && rnw && ackOk; i++)
            byteX(8'hff, i == 6 + blk, rx[i]);
        #30 sdaRel = 1'b0;
        #70 scl = 1'b1;
        #80 sdaRel = 1'b1;
        #160;
    end
    endtask
endmodule

// file: test/scsa_slave_bench.sv
`timescale 1ns/1ps
module scsa_slave_bench;
    reg         core_clk = 1'b0;
    reg         rst = 1'b1;
    reg  [1:0]  slave_addr_strap = 2'h2;
    reg         csrDone = 1'b0;
    reg         csrClaimed = 1'b0;
    reg  [31:0] csrRdData = 32'h0;
    wire        sclIn, sdaRel, sdaOe_n, sdaOut, csrReq, read_not_write;
    wire        read_unclaimed_flag, write_unclaimed_flag;
    wire [15:0] csrByteAddr;
    wire [3:0]  csrByteEn;
    wire [31:0] csrWrData;
    wire [6:0]  slaveAddr;
    wire        sdaIn = sdaRel & (sdaOe_n | sdaOut);
    reg  [15:0] seed = 16'hd3c2;
    reg  [15:0] gotAddr;
    reg  [3:0]  gotBe;
    reg  [31:0] gotData;
    reg  [2:0]  dly = 3'h0;
    reg         gotRnw, expWr = 1'b0;
    integer     errors = 0, n_checks = 0, reqs = 0, k;
    scsa_slave scsa_slave_i (.core_clk, .rst, .slave_addr_strap, .sclIn, .sdaIn, .sdaOe_n, .sdaOut, .csrReq,
        .read_not_write, .csrByteAddr, .csrByteEn, .csrWrData, .csrDone, .csrClaimed, .csrRdData, .slaveAddr,
        .read_unclaimed_flag, .write_unclaimed_flag);
    scsa_master_model scsa_master_model_i (.scl(sclIn), .sdaRel, .sdaLine(sdaIn));
    always #10 core_clk = ~core_clk;
    // ----------------------------------------
    // Register side responder
    // ----------------------------------------
    always @(posedge core_clk)
    begin
        dly <= {dly[1:0], csrReq};
        csrDone <= dly[2];
        if (csrReq)
        begin
            {gotAddr, gotBe, gotData, gotRnw} <= {csrByteAddr, csrByteEn, csrWrData, read_not_write};
            reqs <= reqs + 1;
        end
    end
    function [15:0] lfsr(input [15:0] v);
        lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function [7:0] expStatus(input wr, input rd, input op, input [3:0] be);
        expStatus = {wr, rd, 1'b0, op, be};
    endfunction
    task rnd(output [31:0] r);
    begin
        seed = lfsr(seed);
        r[15:0] = seed;
        seed = lfsr(seed);
        r[31:16] = seed;
    end
    endtask
    task check(input string name, input [31:0] exp, input [31:0] got);
    begin
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    end
    endtask
    task conclude;
    begin
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    task run(input rnw, input [1:0] size, input [2:0] fn, input [6:0] dev, input corner);
        reg [31:0] a, d, rd;
        integer    n, o;
    begin
        rnd(a);
        rnd(d);
        rnd(rd);
        if (corner)
            a = 32'hffffffff;
        o = size == 2'h2;
        @(posedge core_clk);
        csrClaimed <= d[9];
        csrRdData <= rd;
        n = reqs;
        scsa_master_model_i.xfer(dev, rnw, size, fn, a[17:14], a[13:0], d);
        if (fn != 3'h0 || dev[1:0] != slave_addr_strap)
        begin
            check("refused ack", 0, scsa_master_model_i.ackOk);
            check("refused request", n, reqs);
        end
        else
        begin
            check("ack", 1, scsa_master_model_i.ackOk);
            check("byte address", {a[13:0], 2'h0}, gotAddr);
            check("direction", rnw, gotRnw);
            if (!rnw)
            begin
                expWr = !d[9];
                check("enables", a[17:14], gotBe);
                check("write data", d, gotData);
                check("write flag", expWr, write_unclaimed_flag);
            end
            else
            begin
                if (o)
                    check("count", 7, scsa_master_model_i.rx[0]);
                check("status", expStatus(expWr, !d[9], rnw, a[17:14]), scsa_master_model_i.rx[o]);
                check("echo address", a[13:0], {scsa_master_model_i.rx[o + 2], scsa_master_model_i.rx[o + 1]});
                check("read data", rd, {scsa_master_model_i.rx[o + 6], scsa_master_model_i.rx[o + 5],
                    scsa_master_model_i.rx[o + 4], scsa_master_model_i.rx[o + 3]});
                check("read flag", !d[9], read_unclaimed_flag);
            end
        end
    end
    endtask
    initial
    begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        repeat (8) @(posedge core_clk);
        for (k = 0; k < 16; k++)
            run(k[0], k[2:1], 3'h0, {5'h1d, slave_addr_strap}, k < 2);
        run(1'b0, 2'h0, 3'h1, {5'h1d, slave_addr_strap}, 1'b0);
        run(1'b1, 2'h2, 3'h0, {5'h1d, ~slave_addr_strap}, 1'b0);
        conclude;
    end
    initial
    begin
        repeat (90000) @(posedge core_clk);
        errors++;
        conclude;
    end
endmodule
bind scsa_slave scsa_slave_asserts scsa_slave_asserts_i (.core_clk, .rst, .slave_addr_strap, .sdaOut, .csrReq,
    .read_not_write, .csrByteAddr, .csrDone, .csrClaimed, .slaveAddr, .read_unclaimed_flag, .write_unclaimed_flag);
